// ### hqd_pkg.sv
// hqd_pkg: offsets, field positions and reset values for the host queue command block
// assumes a 16-bit register path with even byte addresses
package hqd_pkg;
  localparam logic [11:0] rxq_cmd_off       = 12'h182;
  localparam logic [11:0] txq_cmd_off       = 12'h180;
  localparam logic [11:0] tx_ptr_off        = 12'h184;
  localparam logic [11:0] isr_off           = 12'h192;
  localparam int          isr_rx_bit        = 13;
  localparam int          dur_sts_bit       = 12;
  localparam int          byte_sts_bit      = 11;
  localparam int          frame_sts_bit     = 10;
  localparam int          ip_offset_bit     = 9;
  localparam int          dur_en_bit        = 7;
  localparam int          byte_en_bit       = 6;
  localparam int          frame_en_bit      = 5;
  localparam int          auto_deq_bit      = 4;
  localparam int          dma_bit           = 3;
  localparam int          err_rel_bit       = 0;
  localparam int          tx_auto_bit       = 14;
  localparam int          ptr_w             = 11;
  localparam int          cnt_w             = 16;
  localparam logic [10:0] ptr_reset         = 11'h000;
  localparam logic [15:0] cmd_reset         = 16'h0000;
  localparam logic [10:0] inc_byte          = 11'h001;
  localparam logic [10:0] inc_word          = 11'h002;
  localparam logic [10:0] inc_dword         = 11'h004;
  localparam logic [1:0]  size_byte         = 2'h0;
  localparam logic [1:0]  size_word         = 2'h1;
  localparam logic [1:0]  size_dword        = 2'h2;

  typedef enum logic [1:0] {
    hqd_rel_idle,
    hqd_rel_busy
  } hqd_rel_type;

  function automatic logic [10:0] hqd_step(input logic [1:0] size);
    unique case (size)
      size_byte:  hqd_step = inc_byte;
      size_word:  hqd_step = inc_word;
      default:    hqd_step = inc_dword;
    endcase
  endfunction
endpackage

// ### hqd_cmd_if.sv
// hqd_cmd_if: decoded host write/read strobes handed from the port to the register file
// assumes a single mclk domain
`timescale 1ns/100ps
interface hqd_cmd_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport port (output reg_wr, output reg_rd, output addr, output wdata, input rdata);
  modport regs (input reg_wr, input reg_rd, input addr, input wdata, output rdata);
endinterface

// ### hqd_host_sync.sv
// hqd_host_sync: synchronises the parallel host pins and turns strobe edges into pulses
// assumes host strobes stay low for at least three mclk periods
`timescale 1ns/100ps
module hqd_host_sync (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // host pins
  input  wire logic        chip_select_low,
  input  wire logic        read_strobe_low,
  input  wire logic        write_strobe_low,
  input  wire logic        cmd_pin,
  input  wire logic [11:0] addr_pin,
  input  wire logic [15:0] data_pin,
  // decoded
  output logic             data_wr,
  output logic             data_rd,
  hqd_cmd_if.port          bus
);
  logic [3:0]  s1_q, s2_q;
  logic        wr_prev_q, rd_prev_q;
  logic [11:0] a1_q, a2_q;
  logic [15:0] d1_q, d2_q;
  logic        wr_act, rd_act;

  // pins are asynchronous, so two stages before any decode
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      a1_q <= 12'h000;
      a2_q <= 12'h000;
      d1_q <= 16'h0000;
      d2_q <= 16'h0000;
    end else begin
      s1_q <= {chip_select_low, read_strobe_low, write_strobe_low, cmd_pin};
      s2_q <= s1_q;
      a1_q <= addr_pin;
      a2_q <= a1_q;
      d1_q <= data_pin;
      d2_q <= d1_q;
    end
  end

  assign wr_act = !s2_q[3] && !s2_q[1];
  assign rd_act = !s2_q[3] && !s2_q[2];

  // edge detect on the second stage only
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
    end
  end

  // cmd low selects the frame data path, high the registers
  assign data_wr    = wr_act && !wr_prev_q && !s2_q[0];
  assign data_rd    = rd_act && !rd_prev_q && !s2_q[0];
  assign bus.reg_wr = wr_act && !wr_prev_q && s2_q[0];
  assign bus.reg_rd = rd_act && !rd_prev_q && s2_q[0];
  assign bus.addr   = a2_q;
  assign bus.wdata  = d2_q;
endmodule

// ### hqd_queue_ctrl.sv
// hqd_queue_ctrl: receive queue command register and transmit frame pointer register
// Behaviour
// - byte threshold enable raises receive interrupt
// - frame threshold enable raises receive interrupt
// - auto dequeue skips to next frame
// - dma bit routes strobes to frame buffers
// - dma blocks all other registers
// - error release frees frame, self clears
// - auto increment steps pointer by size
// - no auto increment leaves pointer alone
// - pointer resets zero, reloads after enqueue
// - cause bits update on isr bit write
// assumes queue status and frame buffer logic sit outside, same mclk
`timescale 1ns/100ps
module hqd_queue_ctrl (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // host pins
  input  wire logic        chip_select_low,
  input  wire logic        read_strobe_low,
  input  wire logic        write_strobe_low,
  input  wire logic        cmd_pin,
  input  wire logic [11:0] addr_pin,
  input  wire logic [15:0] data_pin,
  input  wire logic [1:0]  access_size,
  // host read data
  output logic [15:0]      host_rdata,
  output logic             host_rdata_oe,
  // receive queue status
  input  wire logic [15:0] rx_byte_count,
  input  wire logic [15:0] rx_frame_count,
  input  wire logic [15:0] byte_count_threshold_value,
  input  wire logic [15:0] frame_count_threshold_value,
  input  wire logic        rx_duration_hit,
  input  wire logic        rx_frame_read_done,
  input  wire logic        rx_release_done,
  // transmit queue status
  input  wire logic        tx_enqueued,
  input  wire logic [10:0] tx_next_free,
  // requests to the queues
  output logic             rx_threshold_irq,
  output logic             rx_dequeue,
  output logic             rx_release_req,
  output logic             rx_buf_rd,
  output logic             tx_buf_wr,
  output logic [10:0]      tx_buf_addr,
  output logic [15:0]      tx_buf_wdata,
  output logic             reg_access_en,
  output logic             ip_offset_en
);
  logic        data_wr, data_rd;
  hqd_cmd_if   cmd ();

  logic [15:0] cmd_q;
  logic        tx_auto_q;
  logic [10:0] tx_ptr_q;
  logic [2:0]  cause_q;
  logic        irq_q;
  logic        deq_q, rel_req_q, rbuf_q, twr_q;
  logic [10:0] taddr_q;
  logic [15:0] twdata_q;
  logic [15:0] rdata_q;
  logic        rdata_oe_q;
  logic [1:0]  size1_q, size2_q;
  logic [1:0]  rd1_q, rd2_q;
  logic        acc_en_q;
  hqd_pkg::hqd_rel_type rel_q;
  logic        dma_on, cmd_sel, ptr_sel, isr_sel;
  logic        byte_hit, frame_hit;

  hqd_host_sync u_sync (
    .mclk             (mclk),
    .rst              (rst),
    .chip_select_low  (chip_select_low),
    .read_strobe_low  (read_strobe_low),
    .write_strobe_low (write_strobe_low),
    .cmd_pin          (cmd_pin),
    .addr_pin         (addr_pin),
    .data_pin         (data_pin),
    .data_wr          (data_wr),
    .data_rd          (data_rd),
    .bus              (cmd.port)
  );

  assign dma_on   = cmd_q[hqd_pkg::dma_bit];
  assign cmd_sel  = cmd.addr == hqd_pkg::rxq_cmd_off;
  // during dma only the command register answers
  assign ptr_sel  = cmd.addr == hqd_pkg::tx_ptr_off && !dma_on;
  assign isr_sel  = cmd.addr == hqd_pkg::isr_off && !dma_on;
  assign byte_hit = rx_byte_count > byte_count_threshold_value;
  assign frame_hit = rx_frame_count > frame_count_threshold_value;
  // release bit reads 1 until the buffer is really free, so polling means something
  assign cmd.rdata = cmd_sel ? {cmd_q[15:13], cause_q, cmd_q[9:1], rel_q == hqd_pkg::hqd_rel_busy} :
                     ptr_sel ? {1'b0, tx_auto_q, 3'h0, tx_ptr_q} : 16'h0000;

  // command register; release bit kept by its own machine
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= hqd_pkg::cmd_reset;
    end else if (cmd.reg_wr && cmd_sel) begin
      cmd_q <= cmd.wdata;
      cmd_q[hqd_pkg::err_rel_bit] <= 1'b0;
      cmd_q[12:10] <= 3'h0;
    end
  end

  // release: set on write, cleared only when memory is free
  always_ff @(posedge mclk) begin
    if (rst) begin
      rel_q     <= hqd_pkg::hqd_rel_idle;
      rel_req_q <= 1'b0;
    end else begin
      rel_req_q <= 1'b0;
      unique case (rel_q)
        hqd_pkg::hqd_rel_idle: begin
          if (cmd.reg_wr && cmd_sel && cmd.wdata[hqd_pkg::err_rel_bit]) begin
            rel_q     <= hqd_pkg::hqd_rel_busy;
            rel_req_q <= 1'b1;
          end
        end
        hqd_pkg::hqd_rel_busy: begin
          if (rx_release_done)
            rel_q <= hqd_pkg::hqd_rel_idle;
        end
        default: rel_q <= hqd_pkg::hqd_rel_idle;
      endcase
    end
  end

  // interrupt level while an enabled threshold is exceeded
  always_ff @(posedge mclk) begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= (cmd_q[hqd_pkg::byte_en_bit] && byte_hit) ||
               (cmd_q[hqd_pkg::frame_en_bit] && frame_hit) ||
               (cmd_q[hqd_pkg::dur_en_bit] && rx_duration_hit);
  end

  // cause snapshot taken when software writes 1 to the isr receive bit
  always_ff @(posedge mclk) begin
    if (rst)
      cause_q <= 3'h0;
    else if (cmd.reg_wr && isr_sel && cmd.wdata[hqd_pkg::isr_rx_bit])
      cause_q <= {cmd_q[hqd_pkg::dur_en_bit] && rx_duration_hit,
                  cmd_q[hqd_pkg::byte_en_bit] && byte_hit,
                  cmd_q[hqd_pkg::frame_en_bit] && frame_hit};
  end

  // auto dequeue once the host has read the whole frame
  always_ff @(posedge mclk) begin
    if (rst)
      deq_q <= 1'b0;
    else
      deq_q <= cmd_q[hqd_pkg::auto_deq_bit] && rx_frame_read_done;
  end

  // transmit pointer: auto step, enqueue reload beats a same-cycle step
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_ptr_q  <= hqd_pkg::ptr_reset;
      tx_auto_q <= 1'b0;
    end else begin
      if (cmd.reg_wr && ptr_sel)
        tx_auto_q <= cmd.wdata[hqd_pkg::tx_auto_bit];
      if (tx_enqueued)
        tx_ptr_q <= tx_next_free;
      else if (data_wr && dma_on && tx_auto_q)
        tx_ptr_q <= tx_ptr_q + hqd_pkg::hqd_step(size2_q);
    end
  end

  // frame data strobes pass only while dma is open
  always_ff @(posedge mclk) begin
    if (rst) begin
      rbuf_q   <= 1'b0;
      twr_q    <= 1'b0;
      taddr_q  <= hqd_pkg::ptr_reset;
      twdata_q <= 16'h0000;
    end else begin
      rbuf_q <= data_rd && dma_on;
      twr_q  <= data_wr && dma_on;
      if (data_wr && dma_on) begin
        taddr_q  <= tx_ptr_q;
        twdata_q <= cmd.wdata;
      end
    end
  end

  // read data held for the host, driven while a read strobe is active
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q    <= 16'h0000;
      rdata_oe_q <= 1'b0;
    end else begin
      if (cmd.reg_rd)
        rdata_q <= cmd.rdata;
      rdata_oe_q <= !rd2_q[1] && !rd2_q[0];
    end
  end

  // size and read pins are asynchronous too; two stages keep them in step with the strobes
  always_ff @(posedge mclk) begin
    if (rst) begin
      size1_q <= hqd_pkg::size_word;
      size2_q <= hqd_pkg::size_word;
      rd1_q   <= '1;
      rd2_q   <= '1;
    end else begin
      size1_q <= access_size;
      size2_q <= size1_q;
      rd1_q   <= {chip_select_low, read_strobe_low};
      rd2_q   <= rd1_q;
    end
  end

  // own flop so the access enable output has no gate behind it
  always_ff @(posedge mclk) begin
    if (rst)
      acc_en_q <= 1'b1;
    else if (cmd.reg_wr && cmd_sel)
      acc_en_q <= !cmd.wdata[hqd_pkg::dma_bit];
  end

  // oe trails the pins by three cycles, like every other host decode
  assign host_rdata       = rdata_q;
  assign host_rdata_oe    = rdata_oe_q;
  assign rx_threshold_irq = irq_q;
  assign rx_dequeue       = deq_q;
  assign rx_release_req   = rel_req_q;
  assign rx_buf_rd        = rbuf_q;
  assign tx_buf_wr        = twr_q;
  assign tx_buf_addr      = taddr_q;
  assign tx_buf_wdata     = twdata_q;
  assign reg_access_en    = acc_en_q;
  assign ip_offset_en     = cmd_q[hqd_pkg::ip_offset_bit];
endmodule

// ### hqd_queue_ctrl_sva.sv
// hqd_chk: port-level checks on the queue control block
// assumes one mclk domain, rst synchronous high
`timescale 1ns/100ps
module hqd_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // queue status
  input wire logic [15:0] rx_byte_count,
  input wire logic [15:0] rx_frame_count,
  input wire logic [15:0] byte_count_threshold_value,
  input wire logic [15:0] frame_count_threshold_value,
  input wire logic        rx_duration_hit,
  input wire logic        rx_frame_read_done,
  input wire logic        tx_enqueued,
  input wire logic [10:0] tx_next_free,
  // outputs
  input wire logic        rx_threshold_irq,
  input wire logic        rx_dequeue,
  input wire logic        rx_buf_rd,
  input wire logic        tx_buf_wr,
  input wire logic [10:0] tx_buf_addr,
  input wire logic        reg_access_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // expected pointer known after reset or reload; only steps are checked otherwise
  logic        known_q;
  logic [10:0] exp_q;
  logic [10:0] last_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      known_q <= 1'b1;
      exp_q   <= 11'h000;
    end else if (tx_enqueued) begin
      known_q <= 1'b1;
      exp_q   <= tx_next_free;
    end else if (tx_buf_wr) begin
      known_q <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (tx_buf_wr) begin
      last_q <= tx_buf_addr;
    end
  end
  a_irq_has_cause: assert property (
    rx_threshold_irq |-> $past(rx_byte_count > byte_count_threshold_value
      || rx_frame_count > frame_count_threshold_value || rx_duration_hit))
    else $error("threshold irq without cause");
  a_tx_in_dma: assert property (tx_buf_wr |-> !reg_access_en)
    else $error("tx buffer write outside dma");
  a_rx_in_dma: assert property (rx_buf_rd |-> !reg_access_en)
    else $error("rx buffer read outside dma");
  a_wr_single: assert property (tx_buf_wr |=> !tx_buf_wr)
    else $error("tx buffer write not one cycle");
  a_reload_addr: assert property (tx_buf_wr && known_q |-> tx_buf_addr == exp_q)
    else $error("tx pointer not reset or reloaded");
  a_step_size: assert property (
    tx_buf_wr && !known_q |-> (tx_buf_addr - last_q) inside {11'h000, 11'h001, 11'h002, 11'h004})
    else $error("tx pointer step wrong");
  a_deq_cause: assert property (
    rx_dequeue |-> $past(rx_frame_read_done) || $past(rx_frame_read_done, 2))
    else $error("dequeue without frame read");
  a_reset_idle: assert property (
    disable iff (1'b0) rst |=> reg_access_en && !tx_buf_wr && !rx_threshold_irq)
    else $error("outputs not idle after reset");
  c_irq: cover property (rx_threshold_irq);
  c_step: cover property (tx_buf_wr && !known_q);
  c_deq: cover property (rx_dequeue);
endmodule

bind hqd_queue_ctrl hqd_chk hqd_chk_i (
  .mclk(mclk), .rst(rst), .rx_byte_count(rx_byte_count), .rx_frame_count(rx_frame_count),
  .byte_count_threshold_value(byte_count_threshold_value),
  .frame_count_threshold_value(frame_count_threshold_value), .rx_duration_hit(rx_duration_hit),
  .rx_frame_read_done(rx_frame_read_done), .tx_enqueued(tx_enqueued), .tx_next_free(tx_next_free),
  .rx_threshold_irq(rx_threshold_irq), .rx_dequeue(rx_dequeue), .rx_buf_rd(rx_buf_rd),
  .tx_buf_wr(tx_buf_wr), .tx_buf_addr(tx_buf_addr), .reg_access_en(reg_access_en));

// ### hqd_host_model.sv
// hqd_host_model: behavioural host processor on the parallel bus
// assumes the bench clock; pins change only at rising edges
`timescale 1ns/100ps
module hqd_host_model (
  // clock
  input wire logic        mclk,
  // host pins
  output logic            chip_select_low,
  output logic            read_strobe_low,
  output logic            write_strobe_low,
  output logic            cmd_pin,
  output logic [11:0]     addr_pin,
  output logic [15:0]     data_pin,
  output logic [1:0]      access_size,
  // read data
  input wire logic [15:0] host_rdata
);
  initial begin
    chip_select_low  = 1'b1;
    read_strobe_low  = 1'b1;
    write_strobe_low = 1'b1;
    cmd_pin          = 1'b1;
    addr_pin         = 12'h000;
    data_pin         = 16'h0000;
    access_size      = hqd_pkg::size_word;
  end
  // strobe held 6 cycles, idle at least 5: both above the 3-cycle minimum
  task automatic acc(input logic w, input logic c, input logic [11:0] a,
                     input logic [15:0] d, input logic [1:0] s, output logic [15:0] q);
    @(posedge mclk);
    chip_select_low  <= 1'b0;
    read_strobe_low  <= w;
    write_strobe_low <= !w;
    cmd_pin          <= c;
    addr_pin         <= a;
    data_pin         <= d;
    access_size      <= s;
    repeat (6) @(posedge mclk);
    q = host_rdata;
    chip_select_low  <= 1'b1;
    read_strobe_low  <= 1'b1;
    write_strobe_low <= 1'b1;
    data_pin         <= ~d;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// ### test_host_queue_dma_command_and_tx_pointer.sv
// test_host_queue_dma_command_and_tx_pointer: directed bench for the queue control block
// assumes hqd_host_model plays the host; queue status driven here
`timescale 1ns/100ps
module test_host_queue_dma_command_and_tx_pointer;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n, rd_n, wr_n, cmd;
  logic [11:0] addr;
  logic [15:0] data, rdata, q, bc = 16'h0000, fc = 16'h0000;
  logic [1:0]  sz;
  logic        rdone = 1'b0, reldone = 1'b0, enq = 1'b0;
  logic [10:0] nfree = 11'h000, last_addr;
  logic        irq, deq, rel, brd, bwr;
  logic        acc_en, ipo, oe;
  logic [15:0] bwd;
  int          n_mismatch = 0, check_count = 0, n_wr = 0, n_rd = 0, n_deq = 0, n_rel = 0, n_oe = 0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    n_wr  <= n_wr + int'(bwr);
    n_rd  <= n_rd + int'(brd);
    n_deq <= n_deq + int'(deq);
    n_rel <= n_rel + int'(rel);
    n_oe  <= n_oe + int'(oe);
  end
  hqd_host_model hqd_host_model_i (.mclk(mclk), .chip_select_low(cs_n), .read_strobe_low(rd_n),
    .write_strobe_low(wr_n), .cmd_pin(cmd), .addr_pin(addr), .data_pin(data), .access_size(sz),
    .host_rdata(rdata));
  hqd_queue_ctrl hqd_queue_ctrl_i (.mclk(mclk), .rst(rst), .chip_select_low(cs_n),
    .read_strobe_low(rd_n), .write_strobe_low(wr_n), .cmd_pin(cmd), .addr_pin(addr),
    .data_pin(data), .access_size(sz), .host_rdata(rdata), .host_rdata_oe(oe),
    .rx_byte_count(bc), .rx_frame_count(fc), .byte_count_threshold_value(16'h0010),
    .frame_count_threshold_value(16'h0002), .rx_duration_hit(1'b0), .rx_frame_read_done(rdone),
    .rx_release_done(reldone), .tx_enqueued(enq), .tx_next_free(nfree), .rx_threshold_irq(irq),
    .rx_dequeue(deq), .rx_release_req(rel), .rx_buf_rd(brd), .tx_buf_wr(bwr),
    .tx_buf_addr(last_addr), .tx_buf_wdata(bwd), .reg_access_en(acc_en), .ip_offset_en(ipo));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [15:0] d);
    hqd_host_model_i.acc(1'b1, 1'b1, a, d, hqd_pkg::size_word, q);
  endtask
  // oe stands as long as the strobe is low: six cycles in the host model
  task automatic rreg(input logic [11:0] a, input logic [15:0] e);
    int oe0;
    oe0 = n_oe;
    hqd_host_model_i.acc(1'b0, 1'b1, a, 16'h0000, hqd_pkg::size_word, q);
    chk("reg read", e, q);
    chk("host_rdata_oe cycles", 16'h0006, 16'(n_oe - oe0));
  endtask
  // data write; tx_buf_addr and data are sampled while held after the pulse
  task automatic dwr(input logic [1:0] s, input logic [10:0] e);
    hqd_host_model_i.acc(1'b1, 1'b0, 12'h000, {5'h0a, e}, s, q);
    chk("tx_buf_addr", {5'h00, e}, {5'h00, last_addr});
    chk("tx_buf_wdata", {5'h0a, e}, bwd);
  endtask
  task automatic t_thresh();
    bc <= 16'h0010;
    wreg(12'h182, 16'h0040);
    chk("irq at equal", 16'h0000, {15'h0000, irq});
    bc <= 16'h0011;
    repeat (3) @(posedge mclk);
    chk("irq byte", 16'h0001, {15'h0000, irq});
    wreg(hqd_pkg::isr_off, 16'h2000);
    rreg(12'h182, 16'h0840);
    bc <= 16'h0000;
    fc <= 16'h0003;
    wreg(12'h182, 16'h0020);
    chk("irq frame", 16'h0001, {15'h0000, irq});
    fc <= 16'h0002;
    repeat (3) @(posedge mclk);
    chk("irq frame equal", 16'h0000, {15'h0000, irq});
  endtask
  task automatic t_deq(input logic [15:0] en, input int e);
    wreg(12'h182, en);
    @(posedge mclk) rdone <= 1'b1;
    @(posedge mclk) rdone <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("dequeue count", e[15:0], n_deq[15:0]);
  endtask
  task automatic t_dma();
    wreg(12'h184, 16'h4000);
    wreg(12'h182, 16'h0008);
    chk("reg_access_en in dma", 16'h0000, {15'h0000, acc_en});
    dwr(hqd_pkg::size_byte, 11'h000);
    dwr(hqd_pkg::size_word, 11'h001);
    dwr(hqd_pkg::size_dword, 11'h003);
    rreg(12'h184, 16'h0000);
    hqd_host_model_i.acc(1'b0, 1'b0, 12'h000, 16'h0000, hqd_pkg::size_word, q);
    chk("rx buffer reads", 16'h0001, n_rd[15:0]);
    wreg(12'h182, 16'h0000);
    chk("reg_access_en after dma", 16'h0001, {15'h0000, acc_en});
    rreg(12'h184, 16'h4007);
    hqd_host_model_i.acc(1'b1, 1'b0, 12'h000, 16'h0000, hqd_pkg::size_word, q);
    chk("tx writes without dma", 16'h0003, n_wr[15:0]);
  endtask
  task automatic t_manual();
    wreg(12'h184, 16'h0000);
    wreg(12'h182, 16'h0008);
    dwr(hqd_pkg::size_word, 11'h007);
    dwr(hqd_pkg::size_word, 11'h007);
    @(posedge mclk) begin
      enq   <= 1'b1;
      nfree <= 11'h123;
    end
    @(posedge mclk) enq <= 1'b0;
    dwr(hqd_pkg::size_word, 11'h123);
    wreg(12'h182, 16'h0000);
    rreg(12'h184, 16'h0123);
  endtask
  task automatic t_release();
    wreg(12'h182, 16'h0201);
    chk("release requests", 16'h0001, n_rel[15:0]);
    chk("ip_offset_en", 16'h0001, {15'h0000, ipo});
    rreg(12'h182, 16'h0a01);
    @(posedge mclk) reldone <= 1'b1;
    @(posedge mclk) reldone <= 1'b0;
    rreg(12'h182, 16'h0a00);
    rreg(12'h1f0, 16'h0000);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    rreg(12'h182, 16'h0000);
    rreg(12'h184, 16'h0000);
    t_thresh();
    t_deq(16'h0010, 1);
    t_deq(16'h0000, 1);
    t_dma();
    t_manual();
    t_release();
    complete_run();
  end
endmodule
